// ==== dv/sec_link_props.sv ====
// Checker for the serial link between the host and device ends.
// Assumes tb instantiates it beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module sec_link_props #(
  parameter int PROG_ALL_CYCLES = 300
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link
  input wire logic chipSelect,
  input wire logic serialClock,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn,
  // Device status
  input wire logic progBusy,
  input wire logic writeEnabled
);
  logic [7:0] csLow;
  logic [20:0] busyCnt;
  // Saturates high in reset so the first select is not flagged
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      csLow <= 8'hFF;
      busyCnt <= 21'h0;
    end
    else
    begin
      csLow <= chipSelect ? 8'h00 : (csLow == 8'hFF ? csLow : csLow + 8'h01);
      busyCnt <= progBusy ? busyCnt + 21'h1 : 21'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_out_released: assert property (csLow >= 8'h08 |-> !serialOutEn)
    else $error("data-out driven while deselected");
  chk_busy_status: assert property (progBusy && $past(progBusy) && serialOutEn |-> !serialOut)
    else $error("status not low while busy");
  chk_busy_bound: assert property (busyCnt <= 21'(PROG_ALL_CYCLES))
    else $error("program cycle too long");
  chk_prog_deselect: assert property ($rose(progBusy) |-> !chipSelect && !$past(chipSelect))
    else $error("program began while selected");
  chk_prog_enabled: assert property ($rose(progBusy) |-> writeEnabled)
    else $error("program began while disabled");
  chk_start_disabled: assert property ($rose(rst_b) |-> !writeEnabled)
    else $error("enable latch set after reset");
  chk_din_setup: assert property ($rose(serialClock) |-> $stable(serialIn) && chipSelect)
    else $error("data-in moved at clock edge");
  chk_din_hold: assert property (serialClock && $past(serialClock) |-> $stable(serialIn))
    else $error("data-in moved in high phase");
  chk_select_gap: assert property ($rose(chipSelect) |-> csLow >= 8'h3C)
    else $error("select low time too short");
  cover property ($rose(progBusy));
  cover property (serialOutEn && !serialOut);
  cover property (serialOutEn && serialOut && !progBusy);
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Testbench: APB-driven host end facing the device end over the link.
// Assumes short program cycles; a byte model predicts every read.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic widthStrap = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic progBusy;
  logic writeEnabled;
  logic [7:0] mem [128];
  logic [7:0] seed = 8'h52;
  logic [15:0] got;
  logic width_strap = 1'b1;
  logic wen = 1'b0;
  int n_fail = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  sec_link_if link ();
  sec_host u_sec_host (.clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.host));
  // Short program cycles keep the run brief
  sec_device #(.PROG_ONE_CYCLES(200), .PROG_ALL_CYCLES(300)) u_sec_device (.clk(clk),
    .rst_b(rst_b), .ce(1'b1), .widthStrap(widthStrap), .progBusy(progBusy),
    .writeEnabled(writeEnabled), .link(link.dev));
  sec_link_props #(.PROG_ALL_CYCLES(300)) u_props (.clk(clk), .rst_b(rst_b),
    .chipSelect(link.chipSelect), .serialClock(link.serialClock), .serialIn(link.serialIn),
    .serialOut(link.serialOut), .serialOutEn(link.serialOutEn), .progBusy(progBusy),
    .writeEnabled(writeEnabled));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] expw(input logic [6:0] a);
    return width_strap ? {mem[{a[5:0], 1'b0}], mem[{a[5:0], 1'b1}]} : {8'h00, mem[a]};
  endfunction
  task automatic miss(input logic [15:0] g, input logic [15:0] e);
    n_fail++;
    $display("unexpected at %0t: got %h expected %h", $time, g, e);
  endtask
  task automatic check_word(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
      miss(g, e);
  endtask
  task automatic check_flag(input logic g, input logic e);
    n_tests++;
    if (g !== e)
      miss({15'h0, g}, {15'h0, e});
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issues one command, waits for idle, updates the model
  task automatic op(input sec_pkg::sec_kind_type k, input logic [6:0] a);
    logic [15:0] d;
    logic [31:0] r;
    int i;
    seed = lfsr(seed);
    d[15:8] = seed;
    seed = lfsr(seed);
    d[7:0] = seed;
    apb(1'b1, sec_pkg::REG_WDATA, {16'h0, d}, r);
    apb(1'b1, sec_pkg::REG_CMD, 32'(k) | (32'(width_strap) << 4) | (32'(a) << 8), r);
    repeat (3) @(posedge clk);
    r = 32'h1;
    for (i = 0; i < 4000 && r[0] !== 1'b0; i++)
      apb(1'b0, sec_pkg::REG_STATUS, 32'h0, r);
    check_flag(r[0], 1'b0);
    check_flag(r[2], width_strap);
    if (k == sec_pkg::K_ENABLE)
      wen = 1'b1;
    if (k == sec_pkg::K_DISABLE)
      wen = 1'b0;
    if (wen && k == sec_pkg::K_WRITE && width_strap)
      {mem[{a[5:0], 1'b0}], mem[{a[5:0], 1'b1}]} = d;
    if (wen && k == sec_pkg::K_WRITE && !width_strap)
      mem[a] = d[7:0];
    if (wen && k == sec_pkg::K_ERASE && width_strap)
      {mem[{a[5:0], 1'b0}], mem[{a[5:0], 1'b1}]} = 16'hFFFF;
    if (wen && k == sec_pkg::K_ERASE && !width_strap)
      mem[a] = 8'hFF;
    for (i = 0; i < 128; i++)
    begin
      if (wen && k == sec_pkg::K_CLEAR_ALL)
        mem[i] = 8'hFF;
      if (wen && k == sec_pkg::K_FILL_ALL)
        mem[i] = (width_strap && !i[0]) ? d[15:8] : d[7:0];
    end
    apb(1'b0, sec_pkg::REG_RDATA, 32'h0, r);
    got = width_strap ? r[15:0] : {8'h00, r[7:0]};
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    for (int j = 0; j < 128; j++)
      mem[j] = 8'hFF;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    check_flag(writeEnabled, 1'b0);
    op(sec_pkg::K_WRITE, 7'h05);
    op(sec_pkg::K_READ, 7'h05);
    check_word(got, expw(7'h05));
    $display("test locked write done");
    op(sec_pkg::K_ENABLE, 7'h00);
    check_flag(writeEnabled, 1'b1);
    for (int j = 0; j < 2; j++)
    begin
      op(sec_pkg::K_WRITE, 7'h05);
      op(sec_pkg::K_READ, 7'h05);
      check_word(got, expw(7'h05));
    end
    op(sec_pkg::K_WRITE, 7'h3F);
    op(sec_pkg::K_READ, 7'h3F);
    check_word(got, expw(7'h3F));
    op(sec_pkg::K_ERASE, 7'h05);
    op(sec_pkg::K_READ, 7'h05);
    check_word(got, expw(7'h05));
    op(sec_pkg::K_FILL_ALL, 7'h00);
    op(sec_pkg::K_READ, 7'h00);
    check_word(got, expw(7'h00));
    op(sec_pkg::K_CLEAR_ALL, 7'h00);
    op(sec_pkg::K_READ, 7'h28);
    check_word(got, expw(7'h28));
    $display("test program done");
    op(sec_pkg::K_DISABLE, 7'h00);
    check_flag(writeEnabled, 1'b0);
    op(sec_pkg::K_WRITE, 7'h03);
    op(sec_pkg::K_READ, 7'h03);
    check_word(got, expw(7'h03));
    $display("test disable done");
    width_strap = 1'b0;
    widthStrap <= 1'b0;
    repeat (4) @(posedge clk);
    op(sec_pkg::K_ENABLE, 7'h00);
    op(sec_pkg::K_WRITE, 7'h7F);
    op(sec_pkg::K_READ, 7'h7F);
    check_word(got, expw(7'h7F));
    op(sec_pkg::K_ERASE, 7'h7F);
    op(sec_pkg::K_READ, 7'h7F);
    check_word(got, expw(7'h7F));
    $display("test byte mode done");
    results();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    results();
  end
endmodule
`default_nettype wire

// ==== rtl/sec_device.sv ====
// Device end: command decoder, array and self-timed program cycle.
// Assumes link pins arrive asynchronously and are synchronised here.
// What this block does
// - Header 9 bits halfword, 10 bits byte
// - Sample input on serial clock rising edge
// - Output released except read or status
// - Selected status: low busy, high ready
// - Clocked 1 releases status output
// - Status release ignored while busy
// - Start bit, opcode, address, optional data
// - Read: dummy 0 then word MSB first
// - Read bits change on rising edge
// - Sequential read advances, wraps to zero
// - Starts disabled; enable command sets latch
// - Disable command blocks all programming
// - Reads work regardless of enable latch
// - Write starts on select falling edge
// - Host keeps select low minimum time
// - Program cycle needs no serial clock
// - Write clears location before storing
// - Erase sets addressed location to ones
// - Clear-all sets whole array to ones
// - Fill-all writes word everywhere
// - Single cycle 3 ms, whole-array 5 ms
`timescale 1ns/10ps
`default_nettype none
module sec_device #(
  parameter int PROG_ONE_CYCLES = sec_pkg::PROG_ONE_CYCLES,
  parameter int PROG_ALL_CYCLES = sec_pkg::PROG_ALL_CYCLES
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Strap and status
  input wire logic widthStrap,
  output logic progBusy,
  output logic writeEnabled,
  // Serial link
  sec_link_if.dev link
);
  typedef enum logic [2:0] {D_IDLE, D_HDR, D_DATA, D_READ, D_HOLD} sec_dstate_type;
  typedef enum logic [2:0] {A_NONE, A_WRITE, A_ERASE, A_CLEAR_ALL, A_FILL_ALL} sec_act_type;
  typedef struct packed {
    sec_dstate_type st;
    logic [4:0] cnt;
    logic [sec_pkg::HDR_W-1:0] hdr;
    logic [sec_pkg::ADDR_W-1:0] addr;
    logic [sec_pkg::WORD_W-1:0] data;
    sec_act_type cmd;
    sec_act_type pend;
    logic wen;
    logic [sec_pkg::PROG_CNT_W-1:0] timer;
    logic statusOn;
    logic prevSk;
    logic prevCs;
    logic org16;
    logic outBit;
    logic outEn;
    logic [sec_pkg::MEM_BYTES-1:0][sec_pkg::BYTE_W-1:0] mem;
  } sec_dev_type;

  sec_dev_type r, next_r;
  logic csS, skS, dinS, strapS;

  sec_sync3 u_cs (.clk(clk), .rst_b(rst_b), .ce(ce), .pinIn(link.chipSelect), .q(csS));
  sec_sync3 u_sk (.clk(clk), .rst_b(rst_b), .ce(ce), .pinIn(link.serialClock), .q(skS));
  sec_sync3 u_di (.clk(clk), .rst_b(rst_b), .ce(ce), .pinIn(link.serialIn), .q(dinS));
  sec_sync3 u_org (.clk(clk), .rst_b(rst_b), .ce(ce), .pinIn(widthStrap), .q(strapS));

  function automatic logic [1:0] opOf(input logic [8:0] h, input logic o16);
    opOf = o16 ? h[7:6] : h[8:7];
  endfunction

  function automatic logic [1:0] subOf(input logic [8:0] h, input logic o16);
    subOf = o16 ? h[5:4] : h[6:5];
  endfunction

  function automatic logic [6:0] addrOf(input logic [8:0] h, input logic o16);
    addrOf = o16 ? {1'b0, h[5:0]} : h[6:0];
  endfunction

  function automatic logic readBit(
    input logic [127:0][7:0] m, input logic [6:0] a, input logic o16,
    input logic [3:0] idx);
    logic [15:0] w;
    w = {m[{a[5:0], 1'b0}], m[{a[5:0], 1'b1}]};
    if (o16)
      readBit = w[4'hF - idx];
    else
      readBit = m[a][3'h7 - idx[2:0]];
  endfunction

  logic skRise, csFall, busy, lastHdr, lastWord;
  logic [8:0] nh;
  logic [1:0] op;
  logic [6:0] a;

  always_comb
  begin
    next_r = r;
    skRise = skS && !r.prevSk;
    csFall = !csS && r.prevCs;
    busy = (r.timer != '0);
    nh = {r.hdr[7:0], dinS};
    op = opOf(nh, r.org16);
    a = addrOf(nh, r.org16);
    lastHdr = (r.cnt == (r.org16 ? 5'h7 : 5'h8));
    lastWord = (r.cnt == (r.org16 ? 5'hF : 5'h7));
    next_r.prevSk = skS;
    next_r.prevCs = csS;
    // Program cycle runs from clk alone
    if (busy)
    begin
      next_r.timer = r.timer - 1'b1;
    end
    if (r.st == D_IDLE && !busy)
    begin
      next_r.org16 = strapS;
    end
    if (!csS)
    begin
      next_r.st = D_IDLE;
      next_r.cnt = '0;
      next_r.outEn = 1'b0;
      if (!busy)
      begin
        next_r.statusOn = 1'b0;
      end
      if (csFall && r.pend != A_NONE)
      begin
        next_r.statusOn = 1'b1;
        next_r.pend = A_NONE;
        next_r.timer = sec_pkg::PROG_CNT_W'(PROG_ONE_CYCLES);
        case (r.pend)
          A_WRITE, A_ERASE:
          begin
            // Whole location replaced, so no prior erase is needed
            if (r.org16)
            begin
              next_r.mem[{r.addr[5:0], 1'b0}] = (r.pend == A_WRITE) ?
                r.data[15:8] : sec_pkg::ERASED_BYTE;
              next_r.mem[{r.addr[5:0], 1'b1}] = (r.pend == A_WRITE) ?
                r.data[7:0] : sec_pkg::ERASED_BYTE;
            end
            else
            begin
              next_r.mem[r.addr] = (r.pend == A_WRITE) ? r.data[7:0] : sec_pkg::ERASED_BYTE;
            end
          end
          A_CLEAR_ALL:
          begin
            next_r.timer = sec_pkg::PROG_CNT_W'(PROG_ALL_CYCLES);
            for (int i = 0; i < sec_pkg::MEM_BYTES; i++)
            begin
              next_r.mem[i] = sec_pkg::ERASED_BYTE;
            end
          end
          A_FILL_ALL:
          begin
            next_r.timer = sec_pkg::PROG_CNT_W'(PROG_ALL_CYCLES);
            for (int i = 0; i < sec_pkg::MEM_BYTES; i++)
            begin
              next_r.mem[i] = (r.org16 && (i % 2 == 0)) ? r.data[15:8] : r.data[7:0];
            end
          end
          default:
          begin
            next_r.timer = r.timer;
          end
        endcase
      end
    end
    else
    begin
      if (r.statusOn)
      begin
        next_r.outEn = 1'b1;
        next_r.outBit = !busy;
      end
      if (skRise)
      begin
        case (r.st)
          D_IDLE:
          begin
            // Leading zeros skipped; a 1 starts a command only when ready
            if (dinS && !busy)
            begin
              next_r.statusOn = 1'b0;
              next_r.outEn = 1'b0;
              next_r.st = D_HDR;
              next_r.cnt = '0;
            end
          end
          D_HDR:
          begin
            next_r.hdr = nh;
            next_r.cnt = r.cnt + 1'b1;
            if (lastHdr)
            begin
              next_r.cnt = '0;
              next_r.addr = a;
              next_r.st = D_HOLD;
              case (op)
                sec_pkg::OP_READ:
                begin
                  next_r.st = D_READ;
                  next_r.outEn = 1'b1;
                  next_r.outBit = 1'b0;
                end
                sec_pkg::OP_WRITE:
                begin
                  next_r.st = D_DATA;
                  next_r.cmd = A_WRITE;
                end
                sec_pkg::OP_ERASE:
                begin
                  next_r.pend = r.wen ? A_ERASE : A_NONE;
                end
                default:
                begin
                  case (subOf(nh, r.org16))
                    sec_pkg::SUB_ENABLE: next_r.wen = 1'b1;
                    sec_pkg::SUB_DISABLE: next_r.wen = 1'b0;
                    sec_pkg::SUB_CLEAR_ALL: next_r.pend = r.wen ? A_CLEAR_ALL : A_NONE;
                    default:
                    begin
                      next_r.st = D_DATA;
                      next_r.cmd = A_FILL_ALL;
                    end
                  endcase
                end
              endcase
            end
          end
          D_DATA:
          begin
            next_r.data = {r.data[14:0], dinS};
            next_r.cnt = r.cnt + 1'b1;
            if (lastWord)
            begin
              next_r.st = D_HOLD;
              next_r.pend = r.wen ? r.cmd : A_NONE;
            end
          end
          D_READ:
          begin
            next_r.outEn = 1'b1;
            next_r.outBit = readBit(r.mem, r.addr, r.org16, r.cnt[3:0]);
            next_r.cnt = r.cnt + 1'b1;
            if (lastWord)
            begin
              next_r.cnt = '0;
              next_r.addr = r.org16 ? {1'b0, r.addr[5:0] + 6'h1} : r.addr + 7'h1;
            end
          end
          default:
          begin
            next_r.st = D_HOLD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.mem <= '1;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  assign link.serialOut = r.outBit;
  assign link.serialOutEn = r.outEn;
  assign progBusy = (r.timer != '0);
  assign writeEnabled = r.wen;
endmodule
`default_nettype wire

// ==== rtl/sec_host.sv ====
// Host end: APB-programmed controller that frames commands onto the link.
// Assumes the serial clock is made here by dividing clk.
`timescale 1ns/10ps
`default_nettype none
module sec_host (
  // Clock and control
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  sec_link_if.host link
);
  typedef enum logic [2:0] {H_IDLE, H_SEL, H_LO, H_HI, H_GAP, H_POLL, H_END} sec_hstate_type;
  typedef struct packed {
    sec_hstate_type st;
    logic [7:0] timer;
    logic [sec_pkg::FRAME_W-1:0] frame;
    logic [4:0] idx;
    logic [4:0] total;
    logic [4:0] hdrN;
    logic isRead;
    logic isProg;
    logic org16;
    logic ready;
    logic [sec_pkg::WORD_W-1:0] wdata;
    logic [sec_pkg::WORD_W-1:0] rdata;
    logic [31:0] prdata;
    logic cs;
    logic sk;
    logic din;
  } sec_host_type;

  sec_host_type r, next_r;
  logic lineS, acc, mapped, tEnd;
  sec_pkg::sec_kind_type kind;
  logic [1:0] op, sub;
  logic [6:0] ad, af;
  logic [15:0] dw;

  sec_sync3 u_do (.clk(clk), .rst_b(rst_b), .ce(ce), .pinIn(link.lineLevel), .q(lineS));

  always_comb
  begin
    next_r = r;
    acc = psel && penable;
    mapped = (paddr == sec_pkg::REG_CMD) || (paddr == sec_pkg::REG_WDATA) ||
      (paddr == sec_pkg::REG_STATUS) || (paddr == sec_pkg::REG_RDATA);
    tEnd = (r.timer == 8'h0);
    kind = sec_pkg::sec_kind_type'(pwdata[sec_pkg::CMD_KIND_LSB +: 3]);
    ad = pwdata[sec_pkg::CMD_ADDR_LSB +: 7];
    op = sec_pkg::OP_SPECIAL;
    sub = sec_pkg::SUB_DISABLE;
    case (kind)
      sec_pkg::K_READ: op = sec_pkg::OP_READ;
      sec_pkg::K_WRITE: op = sec_pkg::OP_WRITE;
      sec_pkg::K_ERASE: op = sec_pkg::OP_ERASE;
      sec_pkg::K_ENABLE: sub = sec_pkg::SUB_ENABLE;
      sec_pkg::K_CLEAR_ALL: sub = sec_pkg::SUB_CLEAR_ALL;
      sec_pkg::K_FILL_ALL: sub = sec_pkg::SUB_FILL_ALL;
      default: sub = sec_pkg::SUB_DISABLE;
    endcase
    af = (op == sec_pkg::OP_SPECIAL) ? {sub, 5'h0} : ad;
    dw = (kind == sec_pkg::K_WRITE || kind == sec_pkg::K_FILL_ALL) ? r.wdata : 16'h0;
    if (!tEnd)
    begin
      next_r.timer = r.timer - 8'h1;
    end
    // Read data registered in setup so it stands through the access phase
    if (psel && !penable)
    begin
      case (paddr)
        sec_pkg::REG_WDATA: next_r.prdata = {16'h0, r.wdata};
        sec_pkg::REG_RDATA: next_r.prdata = {16'h0, r.rdata};
        sec_pkg::REG_STATUS:
        begin
          next_r.prdata = 32'h0;
          next_r.prdata[sec_pkg::STAT_BUSY_BIT] = (r.st != H_IDLE);
          next_r.prdata[sec_pkg::STAT_READY_BIT] = r.ready;
          next_r.prdata[sec_pkg::STAT_ORG16_BIT] = r.org16;
        end
        default: next_r.prdata = 32'h0;
      endcase
    end
    if (acc && pwrite && paddr == sec_pkg::REG_WDATA && r.st == H_IDLE)
    begin
      next_r.wdata = pwdata[15:0];
    end
    case (r.st)
      H_IDLE:
      begin
        // A new command is refused while one is still running
        if (acc && pwrite && paddr == sec_pkg::REG_CMD)
        begin
          next_r.org16 = pwdata[sec_pkg::CMD_ORG16_BIT];
          next_r.isRead = (kind == sec_pkg::K_READ);
          next_r.isProg = (kind == sec_pkg::K_WRITE) || (kind == sec_pkg::K_ERASE) ||
            (kind == sec_pkg::K_CLEAR_ALL) || (kind == sec_pkg::K_FILL_ALL);
          next_r.ready = 1'b0;
          next_r.rdata = 16'h0;
          next_r.idx = 5'h0;
          if (pwdata[sec_pkg::CMD_ORG16_BIT])
          begin
            next_r.frame = {1'b1, op, (op == sec_pkg::OP_SPECIAL) ? {sub, 4'h0} : ad[5:0],
              dw, 2'h0};
            next_r.hdrN = 5'(sec_pkg::HDR_BITS_HALFWORD);
            next_r.total = 5'(sec_pkg::HDR_BITS_HALFWORD) +
              ((dw != 16'h0 || kind == sec_pkg::K_WRITE || kind == sec_pkg::K_FILL_ALL ||
              kind == sec_pkg::K_READ) ? 5'h10 : 5'h0);
          end
          else
          begin
            next_r.frame = {1'b1, op, af, dw[7:0], 9'h0};
            next_r.hdrN = 5'(sec_pkg::HDR_BITS_BYTE);
            next_r.total = 5'(sec_pkg::HDR_BITS_BYTE) +
              ((kind == sec_pkg::K_WRITE || kind == sec_pkg::K_FILL_ALL ||
              kind == sec_pkg::K_READ) ? 5'h8 : 5'h0);
          end
          next_r.cs = 1'b1;
          next_r.st = H_SEL;
          next_r.timer = 8'(sec_pkg::SK_HALF_CYCLES);
        end
      end
      H_SEL, H_HI:
      begin
        if (tEnd)
        begin
          if (r.st == H_HI)
          begin
            next_r.sk = 1'b0;
            if (r.isRead && r.idx >= r.hdrN)
            begin
              next_r.rdata = {r.rdata[14:0], lineS};
            end
          end
          if (r.st == H_HI && r.idx == r.total)
          begin
            next_r.cs = 1'b0;
            next_r.din = 1'b0;
            next_r.st = H_GAP;
            next_r.timer = 8'(sec_pkg::MIN_SELECT_LOW_CYCLES);
          end
          else
          begin
            next_r.din = r.frame[sec_pkg::FRAME_W-1];
            next_r.frame = {r.frame[sec_pkg::FRAME_W-2:0], 1'b0};
            next_r.st = H_LO;
            next_r.timer = 8'(sec_pkg::SK_HALF_CYCLES);
          end
        end
      end
      H_LO:
      begin
        if (tEnd)
        begin
          next_r.sk = 1'b1;
          next_r.idx = r.idx + 5'h1;
          next_r.st = H_HI;
          next_r.timer = 8'(sec_pkg::SK_HALF_CYCLES);
        end
      end
      H_GAP:
      begin
        if (tEnd)
        begin
          next_r.st = r.isProg ? H_POLL : H_IDLE;
          next_r.cs = r.isProg;
          next_r.timer = 8'(sec_pkg::SK_HALF_CYCLES);
        end
      end
      H_POLL:
      begin
        // Poll until the device data-out line reads high
        if (tEnd)
        begin
          next_r.timer = 8'(sec_pkg::SK_HALF_CYCLES);
          if (lineS)
          begin
            next_r.ready = 1'b1;
            next_r.cs = 1'b0;
            next_r.st = H_END;
            next_r.timer = 8'(sec_pkg::MIN_SELECT_LOW_CYCLES);
          end
        end
      end
      H_END:
      begin
        if (tEnd)
        begin
          next_r.st = H_IDLE;
        end
      end
      default:
      begin
        next_r.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      r <= '0;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign link.chipSelect = r.cs;
  assign link.serialClock = r.sk;
  assign link.serialIn = r.din;
endmodule
`default_nettype wire

// ==== rtl/sec_link_if.sv ====
// Serial link between host and EEPROM device ends.
// Assumes an idle pull-up on the shared data-out wire.
`timescale 1ns/10ps
`default_nettype none
interface sec_link_if;
  logic chipSelect;
  logic serialClock;
  logic serialIn;
  logic serialOut;
  logic serialOutEn;
  logic lineLevel;
  // Released output reads high, as with a pull-up
  assign lineLevel = serialOutEn ? serialOut : 1'b1;
  modport dev (
    input chipSelect, serialClock, serialIn,
    output serialOut, serialOutEn
  );
  modport host (
    output chipSelect, serialClock, serialIn,
    input lineLevel
  );
endinterface
`default_nettype wire

// ==== rtl/sec_pkg.sv ====
// Constants shared by both ends of the serial EEPROM command port.
// Assumes a 250 MHz system clock on both ends.
package sec_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_ONE_MS = 3;
  localparam int PROG_ALL_MS = 5;
  localparam int PROG_ONE_CYCLES = PROG_ONE_MS * CLK_MHZ * 1000;
  localparam int PROG_ALL_CYCLES = PROG_ALL_MS * CLK_MHZ * 1000;
  localparam int PROG_CNT_W = 21;
  localparam int SK_HALF_NS = 250;
  localparam int SK_HALF_CYCLES = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_SELECT_LOW_NS = 250;
  localparam int MIN_SELECT_LOW_CYCLES =
    (MIN_SELECT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Instruction format
  localparam int ADDR_W = 7;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int MEM_BYTES = 128;
  localparam int HDR_W = 9;
  localparam int HDR_BITS_HALFWORD = 9;
  localparam int HDR_BITS_BYTE = 10;
  localparam int FRAME_W = 27;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL_ALL = 2'h1;
  localparam logic [1:0] SUB_CLEAR_ALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Host register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_ORG16_BIT = 4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_ORG16_BIT = 2;
  // Host command kinds, in register encoding order 0..6
  typedef enum logic [2:0] {
    K_READ, K_WRITE, K_ERASE, K_ENABLE, K_DISABLE, K_CLEAR_ALL, K_FILL_ALL
  } sec_kind_type;
endpackage

// ==== rtl/sec_sync3.sv ====
// Three-stage pin synchroniser with agreement filter.
// Assumes an input asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module sec_sync3 (
  // Clock and control
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Pin and result
  input wire logic pinIn,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sec_sync_type;
  sec_sync_type r, next_r;
  always_comb
  begin
    next_r = r;
    next_r.s1 = pinIn;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // Change accepted once stages two and three agree
    if (r.s2 == r.s3)
    begin
      next_r.q = r.s3;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      r <= '0;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end
  assign q = r.q;
endmodule
`default_nettype wire
